// ==== irm_pkg.sv ====
// shared constants for the internal resource address mapper
package irm_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RAM_POS  = 6'h10;
  localparam logic [5:0] IDX_REGB_POS = 6'h11;
  localparam logic [5:0] IDX_NVM_POS  = 6'h12;
  localparam logic [5:0] IDX_MISC     = 6'h13;
  localparam logic [5:0] IDX_STATUS   = 6'h14;
  // ---------------------------------------------------------------
  // reset values and field masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_RAM_POS   = 8'h00;
  localparam logic [7:0] RST_REGB_POS  = 8'h00;
  localparam logic [7:0] RST_NVM_POS   = 8'h01;
  localparam logic [7:0] RST_MISC_EXP  = 8'h0c;
  localparam logic [7:0] MISC_SC_SET   = 8'h03;
  localparam logic [7:0] MASK_RAM_POS  = 8'hf8;
  localparam logic [7:0] MASK_REGB_FLD = 8'hf8;
  localparam logic [7:0] MASK_REGB_WST = 8'h01;
  localparam logic [7:0] MASK_NVM_FLD  = 8'hf0;
  localparam logic [7:0] MASK_NVM_ON   = 8'h01;
  // ---------------------------------------------------------------
  // misc register bit positions
  // ---------------------------------------------------------------
  localparam int MISC_SWAP   = 7;
  localparam int MISC_NARROW = 6;
  localparam int MISC_WSTR_H = 5;
  localparam int MISC_WSTR_L = 4;
  localparam int MISC_XSTR_H = 3;
  localparam int MISC_XSTR_L = 2;
  localparam int MISC_SMALL  = 1;
  localparam int MISC_LARGE  = 0;
  // ---------------------------------------------------------------
  // address map constants
  // ---------------------------------------------------------------
  localparam logic [1:0] REGB_SUB   = 2'h0;  // first 512 bytes of 2K block
  localparam logic [1:0] WIN_SUB    = 2'h1;  // following 512 bytes
  localparam logic [1:0] NVM_SUB    = 2'h3;  // 1K at offset 0xc00 of 4K
  localparam logic [2:0] LOW_4K     = 3'h0;  // first 4K of a 32K half
  localparam logic [7:0] DBG_PAGE   = 8'hff;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  // ---------------------------------------------------------------
  // one-hot select encoding, highest precedence first
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    SEL_NONE  = 7'h00,
    SEL_DBG   = 7'h40,
    SEL_REGB  = 7'h20,
    SEL_RAM   = 7'h10,
    SEL_NVM   = 7'h08,
    SEL_SMALL = 7'h04,
    SEL_LARGE = 7'h02,
    SEL_EXT   = 7'h01
  } irm_sel_t;
endpackage

// ==== irm_stretch.sv ====
// e clock stretch counter for external bus cycles
`timescale 1ns/10ps
module irm_stretch
  import irm_pkg::*;
#(
  parameter int CNT_W = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // request
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] count,
  // e clock hold
  output logic                  e_hold_high
);
  logic [CNT_W-1:0] cnt_ff;
  logic             hold_ff;

  // load the count on start, then hold e high one cycle per count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= '0;
      hold_ff <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_ff  <= count;
        hold_ff <= (count != '0); // RULE20
      end else if (cnt_ff != '0) begin
        cnt_ff  <= cnt_ff - 1'b1;
        hold_ff <= (cnt_ff != {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign e_hold_high = hold_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_stretch_three: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
    (ce && start && count == 2'h3) ##1 ce[*3] |-> $past(hold_ff, 2) && $past(hold_ff) && hold_ff)
    else $error("stretch of three not held");
  cov_stretch_run: cover property (@(posedge clk) disable iff (sys_rst) ce && start && count != '0);
endmodule

// ==== irm_map_top.sv ====
// address mapper: mapping registers, decode and stretch control
//
// What this block does
// RULE1 - position registers take one write in normal modes, any in special modes
// RULE2 - a written mapping value steers the decode from the next cycle
// RULE3 - overlap precedence: debug, registers, ram, eeprom, program arrays, external
// RULE4 - in expanded modes every unclaimed address goes to external memory
// RULE5 - 512-byte register block at zero after reset, movable to 2K boundaries
// RULE6 - wait-stop bit set blocks all decoding while in wait mode
// RULE7 - wait-stop bit writable in normal modes only, readable always
// RULE8 - 2K ram at zero after reset, five-bit field gives address bits 15..11
// RULE9 - 1K eeprom at 0c00 after reset, four-bit field gives bits 15..12
// RULE10 - eeprom enable inserts or removes eeprom, forced on in single-chip
// RULE11 - misc control takes one write in normal modes, any in special
// RULE12 - swap bit exchanges placement of the 28K and 32K program arrays
// RULE13 - narrow bit makes following window eight bits wide in expanded wide modes
// RULE14 - following window sits right after the register block, 0200 at reset
// RULE15 - following window accesses stretched by its two-bit field, expanded only
// RULE16 - external accesses stretched by the external two-bit field, expanded only
// RULE17 - array enable bits place or remove each program array
// RULE18 - reserved bits of position registers read zero, writes ignored
// RULE19 - special-mode indicator low selects write-anytime, high write-once
// RULE20 - stretched access holds e high for the added cycles
`timescale 1ns/10ps
module irm_map_top
  import irm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CPU_AW = 16
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // operating mode
  input  wire logic              special_mode_indicator_n,
  input  wire logic              mode_expanded,
  input  wire logic              mode_wide,
  input  wire logic              mode_peripheral,
  input  wire logic              wait_mode,
  input  wire logic              background_debug,
  input  wire logic              e_clock_stretch_enable,
  // cpu access
  input  wire logic              cpu_valid,
  input  wire logic [CPU_AW-1:0] cpu_addr,
  // decode result
  output logic                   map_valid,
  output logic [6:0]             map_select,
  output logic                   map_narrow,
  output logic [1:0]             map_stretch,
  output logic                   e_hold_high
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]       ram_pos_ff, regb_pos_ff, nvm_pos_ff, misc_ff;
  logic             ram_once_ff, regb_once_ff, nvm_once_ff, misc_once_ff;
  logic             init_ff;
  logic             awrdy_ff, wrdy_ff, bvalid_ff, arrdy_ff, rvalid_ff;
  logic             aw_got_ff, w_got_ff;
  logic [5:0]       aw_idx_ff;
  logic [7:0]       wdata_ff;
  logic             wstrb_ff;
  logic [1:0]       bresp_ff, rresp_ff;
  logic [31:0]      rdata_ff;
  logic             vld_ff, narrow_ff;
  logic [6:0]       sel_ff;
  logic [1:0]       str_ff;
  irm_sel_t         nxt_sel;
  logic             single_chip, special, w_go, may_once, wait_block;
  logic             hit_dbg, hit_regb, hit_win, hit_ram, hit_nvm, hit_small, hit_large;
  logic             nvm_on, take_acc, stretch_go;
  logic [1:0]       nxt_str;

  assign single_chip = !mode_expanded && !mode_peripheral;
  assign special     = !special_mode_indicator_n;            // RULE19
  assign w_go        = ce && aw_got_ff && w_got_ff && !bvalid_ff && wstrb_ff;
  assign nvm_on      = nvm_pos_ff[0] || single_chip;        // RULE10
  assign wait_block  = wait_mode && regb_pos_ff[0];         // RULE6

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // match a 512-byte slot inside the 2K block named by base
  function automatic logic in_slot(input logic [15:0] a, input logic [4:0] base, input logic [1:0] sub);
    in_slot = (a[15:11] == base) && (a[10:9] == sub);
  endfunction

  // read value of one register index, reserved bits zero
  function automatic logic [7:0] rd_reg(input logic [5:0] idx);
    case (idx)
      IDX_RAM_POS:  rd_reg = ram_pos_ff & MASK_RAM_POS;
      IDX_REGB_POS: rd_reg = regb_pos_ff & (MASK_REGB_FLD | MASK_REGB_WST);      // RULE18
      IDX_NVM_POS:  rd_reg = (nvm_pos_ff & MASK_NVM_FLD) | {7'h00, nvm_on};       // RULE18
      IDX_MISC:     rd_reg = misc_ff;
      IDX_STATUS:   rd_reg = {5'h00, single_chip, wait_block, special_mode_indicator_n};
      default:      rd_reg = 8'h00;
    endcase
  endfunction

  // index is mapped when it names a register
  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx >= IDX_RAM_POS) && (idx <= IDX_STATUS);
  endfunction

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  // capture address and data in either order, answer after both
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awrdy_ff  <= 1'b1;
      wrdy_ff   <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      aw_idx_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && awrdy_ff) begin
        aw_idx_ff <= s_axi_awaddr[7:2];
        aw_got_ff <= 1'b1;
        awrdy_ff  <= 1'b0;
      end
      if (s_axi_wvalid && wrdy_ff) begin
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
        w_got_ff <= 1'b1;
        wrdy_ff  <= 1'b0;
      end
      if (aw_got_ff && w_got_ff && !bvalid_ff) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLV;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awrdy_ff  <= 1'b1;
        wrdy_ff   <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  // one read at a time, answer one cycle after the address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arrdy_ff  <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arrdy_ff) begin
        arrdy_ff  <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h000000, rd_reg(s_axi_araddr[7:2])};
        rresp_ff  <= mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLV;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arrdy_ff  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // mapping registers
  // ---------------------------------------------------------------
  assign may_once = special;

  // ram and register block position, write-once in normal modes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_pos_ff   <= RST_RAM_POS;   // RULE8
      regb_pos_ff  <= RST_REGB_POS;  // RULE5
      ram_once_ff  <= 1'b0;
      regb_once_ff <= 1'b0;
    end else if (w_go) begin
      if (aw_idx_ff == IDX_RAM_POS) begin
        ram_once_ff <= 1'b1;
        if (may_once || !ram_once_ff) begin
          ram_pos_ff <= wdata_ff & MASK_RAM_POS; // RULE1
        end
      end
      if (aw_idx_ff == IDX_REGB_POS) begin
        regb_once_ff <= 1'b1;
        if (may_once || !regb_once_ff) begin
          regb_pos_ff[7:3] <= wdata_ff[7:3]; // RULE1
        end
        if (special_mode_indicator_n) begin
          regb_pos_ff[0] <= wdata_ff[0]; // RULE7
        end
      end
    end
  end

  // eeprom position: field write-once, enable bit any time
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvm_pos_ff  <= RST_NVM_POS; // RULE9
      nvm_once_ff <= 1'b0;
    end else if (w_go && aw_idx_ff == IDX_NVM_POS) begin
      nvm_once_ff   <= 1'b1;
      nvm_pos_ff[0] <= wdata_ff[0]; // RULE10
      if (may_once || !nvm_once_ff) begin
        nvm_pos_ff[7:4] <= wdata_ff[7:4]; // RULE1
      end
    end
  end

  // misc control; array enables come up set in single-chip modes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      misc_ff      <= RST_MISC_EXP;
      misc_once_ff <= 1'b0;
      init_ff      <= 1'b0;
    end else if (ce) begin
      init_ff <= 1'b1;
      if (!init_ff && single_chip) begin
        misc_ff <= RST_MISC_EXP | MISC_SC_SET;
      end else if (w_go && aw_idx_ff == IDX_MISC) begin
        misc_once_ff <= 1'b1;
        if (may_once || !misc_once_ff) begin
          misc_ff <= wdata_ff; // RULE11
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign hit_dbg   = background_debug && (cpu_addr[15:8] == DBG_PAGE);
  assign hit_regb  = in_slot(cpu_addr, regb_pos_ff[7:3], REGB_SUB);          // RULE5
  assign hit_win   = in_slot(cpu_addr, regb_pos_ff[7:3], WIN_SUB);           // RULE14
  assign hit_ram   = (cpu_addr[15:11] == ram_pos_ff[7:3]);                   // RULE8 RULE2
  assign hit_nvm   = nvm_on && (cpu_addr[15:12] == nvm_pos_ff[7:4])
                     && (cpu_addr[11:10] == NVM_SUB);                        // RULE9
  assign hit_small = misc_ff[MISC_SMALL] && (cpu_addr[15] == misc_ff[MISC_SWAP])
                     && (cpu_addr[14:12] != LOW_4K);                         // RULE12 RULE17
  assign hit_large = misc_ff[MISC_LARGE] && (cpu_addr[15] != misc_ff[MISC_SWAP]); // RULE12 RULE17
  assign take_acc  = ce && cpu_valid && !wait_block;                         // RULE6

  // fixed precedence selection
  always_comb begin
    if (hit_dbg) begin
      nxt_sel = SEL_DBG; // RULE3
    end else if (hit_regb) begin
      nxt_sel = SEL_REGB;
    end else if (hit_ram) begin
      nxt_sel = SEL_RAM;
    end else if (hit_nvm) begin
      nxt_sel = SEL_NVM;
    end else if (hit_small) begin
      nxt_sel = SEL_SMALL;
    end else if (hit_large) begin
      nxt_sel = SEL_LARGE;
    end else if (mode_expanded) begin
      nxt_sel = SEL_EXT; // RULE4
    end else begin
      nxt_sel = SEL_NONE;
    end
  end

  // stretch count for SEL_EXT: window field inside the window, else external field; zero for other selections
  always_comb begin
    nxt_str = 2'h0;
    if (nxt_sel == SEL_EXT) begin
      if (hit_win) begin
        nxt_str = {misc_ff[MISC_WSTR_H], misc_ff[MISC_WSTR_L]}; // RULE15
      end else begin
        nxt_str = {misc_ff[MISC_XSTR_H], misc_ff[MISC_XSTR_L]}; // RULE16
      end
    end
  end

  assign stretch_go = take_acc && (nxt_sel == SEL_EXT) && e_clock_stretch_enable;

  // registered decode result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vld_ff    <= 1'b0;
      sel_ff    <= SEL_NONE;
      narrow_ff <= 1'b0;
      str_ff    <= 2'h0;
    end else if (ce) begin
      vld_ff    <= take_acc;
      sel_ff    <= take_acc ? nxt_sel : SEL_NONE;
      narrow_ff <= take_acc && (nxt_sel == SEL_EXT) && hit_win && mode_wide
                   && misc_ff[MISC_NARROW]; // RULE13
      str_ff    <= take_acc ? nxt_str : 2'h0;
    end
  end

  // e clock hold for stretched external cycles
  irm_stretch #(
    .CNT_W (2)
  ) u_stretch (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .start       (stretch_go),
    .count       (nxt_str),
    .e_hold_high (e_hold_high)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awrdy_ff;
  assign s_axi_wready  = wrdy_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arrdy_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign map_valid     = vld_ff;
  assign map_select    = sel_ff;
  assign map_narrow    = narrow_ff;
  assign map_stretch   = str_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_sel_onehot: assert property ($onehot0(sel_ff)) // RULE3
    else $error("select not one-hot");
  chk_reg_over_ram: assert property (take_acc && !hit_dbg && hit_regb |=> sel_ff == SEL_REGB) // RULE3
    else $error("register block lost precedence");
  chk_once_normal: assert property (w_go && aw_idx_ff == IDX_RAM_POS && !special && ram_once_ff
    |=> ram_pos_ff == $past(ram_pos_ff)) // RULE1
    else $error("second ram position write taken in normal mode");
  chk_new_base: assert property (w_go && aw_idx_ff == IDX_REGB_POS && (special || !regb_once_ff)
    |=> regb_pos_ff[7:3] == $past(wdata_ff[7:3])) // RULE2
    else $error("register base not updated next cycle");
  chk_wait_stop: assert property (ce && cpu_valid && wait_mode && regb_pos_ff[0] |=> !vld_ff && sel_ff == SEL_NONE) // RULE6
    else $error("decode active in wait with stop set");
  chk_stop_special: assert property (w_go && special |=> regb_pos_ff[0] == $past(regb_pos_ff[0])) // RULE7
    else $error("wait-stop bit written in special mode");
  chk_ext_default: assert property (take_acc && mode_expanded && !hit_dbg && !hit_regb && !hit_ram
    && !hit_nvm && !hit_small && !hit_large |=> sel_ff == SEL_EXT) // RULE4
    else $error("unclaimed address not external");
  chk_narrow_win: assert property (take_acc && hit_win && !hit_dbg && !hit_ram && !hit_nvm && !hit_small
    && !hit_large && mode_expanded && mode_wide && misc_ff[MISC_NARROW] |=> narrow_ff) // RULE13
    else $error("following window not narrow");
  chk_nvm_forced: assert property (single_chip ##1 (rvalid_ff && $past(s_axi_araddr[7:2]) == IDX_NVM_POS
    && $past(s_axi_arvalid && arrdy_ff)) |-> rdata_ff[0]) // RULE10
    else $error("eeprom enable not forced in single-chip");

  cov_ram_sel: cover property (take_acc ##1 sel_ff == SEL_RAM);
  cov_ext_sel: cover property (take_acc ##1 sel_ff == SEL_EXT);
  cov_reg_write: cover property (w_go && aw_idx_ff == IDX_REGB_POS);
endmodule

// ==== irm_cpu_model.sv ====
// cpu-side access source that feeds decode requests to the mapper
`timescale 1ns/10ps
module irm_cpu_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // command from the bench
  input  wire logic        req,
  input  wire logic [15:0] req_addr,
  // cpu bus
  output logic             cpu_valid,
  output logic [15:0]      cpu_addr
);
  // idle cycles show a changing address so a stale one never looks valid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_valid <= 1'h0;
      cpu_addr  <= 16'h0000;
    end else begin
      cpu_valid <= req;
      cpu_addr  <= req ? req_addr : ~cpu_addr;
    end
  end
endmodule

// ==== tb.sv ====
// self-checking bench for the address mapper
`timescale 1ns/10ps
module tb;
  import irm_pkg::*;
  logic        clk, rst = 1'h1, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic        smn = 1'h1, wm = 1'h0, dbg = 1'h0, es = 1'h1, req = 1'h0, mx = 1'h1, mw = 1'h1;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [15:0] ra = 16'h0;
  logic        awr, wr, bv, arr, rv, cv, mv, mn, eh;
  logic [1:0]  br, rr, ms;
  logic [31:0] rd;
  logic [6:0]  sel;
  logic [15:0] ca;
  logic [31:0] exp_q[$];
  int          miscompares = 0;
  int          cmp_count = 0;

  irm_map_top dut_u (.clk(clk), .sys_rst(rst), .ce(1'h1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .special_mode_indicator_n(smn), .mode_expanded(mx), .mode_wide(mw), .mode_peripheral(1'h0),
    .wait_mode(wm), .background_debug(dbg), .e_clock_stretch_enable(es), .cpu_valid(cv),
    .cpu_addr(ca), .map_valid(mv), .map_select(sel), .map_narrow(mn), .map_stretch(ms),
    .e_hold_high(eh));
  irm_cpu_model cpu_u (.clk(clk), .sys_rst(rst), .req(req), .req_addr(ra), .cpu_valid(cv), .cpu_addr(ca));

  // free-running clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // axi write, address and data offered together, bready held until answer
  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd  <= {24'h0, d};
    awv <= 1'h1;
    wv  <= 1'h1;
    bre <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr) wv <= 1'h0;
      if (bv) break;
    end
    if (n == 100) miscompares++;
    if (n == 100) finish_test();
    check({30'h0, br}, {30'h0, er});
    bre <= 1'h0;
  endtask

  // axi read; the data is judged by the monitor
  task automatic rd_reg(input logic [5:0] idx, input logic [31:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'h1;
    rre <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
      if (rv) break;
    end
    if (n == 100) miscompares++;
    if (n == 100) finish_test();
    check({30'h0, rr}, {30'h0, (idx == 6'h3f) ? RESP_SLV : RESP_OKAY});
    rre <= 1'h0;
  endtask

  // one cpu access; all ones means no decode result is due; returns at capture edge
  task automatic cpu(input logic [15:0] a, input logic [31:0] e);
    if (e != 32'hffffffff) exp_q.push_back(e);
    @(posedge clk);
    req <= 1'h1;
    ra  <= a;
    @(posedge clk);
    req <= 1'h0;
    @(posedge clk);
  endtask

  // monitor: every result takes the oldest note
  always @(posedge clk) begin
    if ((rv && rre) || mv) begin
      if (exp_q.size() == 0) check(32'hdead, 32'h0);
      else if (mv) check({22'h0, mn, ms, sel}, exp_q.pop_front());
      else check(rd, exp_q.pop_front());
    end
  end

  initial begin
    int          i;
    logic [15:0] r;
    r = 16'($urandom(32'h5ab5acf0));
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    rd_reg(IDX_RAM_POS, 32'h00);
    rd_reg(IDX_REGB_POS, 32'h00);
    rd_reg(IDX_NVM_POS, 32'h01);
    rd_reg(IDX_MISC, 32'h0c);
    rd_reg(6'h3f, 32'h00);
    cpu(16'h0000, 32'h20);
    cpu(16'h0200, 32'h10);
    cpu(16'h0c00, 32'h08);
    dbg <= 1'h1;
    cpu(16'h1000, 32'h181);
    for (i = 0; i < 4; i++) begin
      #1 check({31'h0, eh}, (i < 3) ? 32'h1 : 32'h0);
      @(posedge clk);
    end
    cpu(16'hff10, 32'h40);
    dbg <= 1'h0;
    $display("reset map test done");
    wr_reg(IDX_MISC, 8'h83, RESP_OKAY);
    wr_reg(IDX_MISC, 8'h00, RESP_OKAY);
    rd_reg(IDX_MISC, 32'h83);
    cpu(16'h1000, 32'h02);
    cpu(16'h9000, 32'h04);
    wr_reg(IDX_REGB_POS, 8'h0f, RESP_OKAY);
    rd_reg(IDX_REGB_POS, 32'h09);
    cpu(16'h0800, 32'h20);
    wm <= 1'h1;
    cpu(16'h0800, 32'hffffffff);
    wm <= 1'h0;
    for (i = 0; i < 8; i++) begin
      r = 16'($urandom()) & 16'h07ff;
      cpu(r, 32'h10);
    end
    $display("relocation test done");
    wr_reg(IDX_NVM_POS, 8'hff, RESP_OKAY);
    rd_reg(IDX_NVM_POS, 32'hf1);
    cpu(16'hfc00, 32'h08);
    wr_reg(IDX_NVM_POS, 8'h00, RESP_OKAY);
    rd_reg(IDX_NVM_POS, 32'hf0);
    cpu(16'hfc00, 32'h04);
    wr_reg(6'h3f, 8'h55, RESP_SLV);
    wr_reg(IDX_RAM_POS, 8'h17, RESP_OKAY);
    wr_reg(IDX_RAM_POS, 8'h00, RESP_OKAY);
    rd_reg(IDX_RAM_POS, 32'h10);
    cpu(16'h1000, 32'h10);
    $display("write once test done");
    smn <= 1'h0;
    wr_reg(IDX_RAM_POS, 8'h20, RESP_OKAY);
    rd_reg(IDX_RAM_POS, 32'h20);
    wr_reg(IDX_REGB_POS, 8'h10, RESP_OKAY);
    rd_reg(IDX_REGB_POS, 32'h11);
    repeat (4) @(posedge clk);
    $display("special mode test done");
    // following window at 1200 with the register block at 1000: narrow bit and window stretch
    wr_reg(IDX_MISC, 8'h50, RESP_OKAY);
    cpu(16'h1200, 32'h281);
    mw <= 1'h0;
    cpu(16'h1200, 32'h081);
    es <= 1'h0;
    cpu(16'h1200, 32'h081);
    #1 check({31'h0, eh}, 32'h0);
    // single-chip: eeprom enable reads forced, unclaimed space selects nothing
    mx <= 1'h0;
    rd_reg(IDX_NVM_POS, 32'hf1);
    rd_reg(IDX_STATUS, 32'h04);
    cpu(16'h4000, 32'h00);
    repeat (4) @(posedge clk);
    $display("mode test done");
    finish_test();
  end
endmodule
